// File: rtl/smp_cfg.svh
// Constants for the strap and miscellaneous pin control block.
// Assumes a 32-bit AHB-Lite register bus and a 200 MHz core clock.
`ifndef SMP_CFG_SVH
`define SMP_CFG_SVH

// Register byte addresses
`define SMP_ADDR_CTRL      12'h000
`define SMP_ADDR_STATUS    12'h004
`define SMP_ADDR_LINK      12'h008
`define SMP_ADDR_W         12

// Control register fields
`define SMP_CTRL_OE_LSB    0
`define SMP_CTRL_OUT_LSB   8
`define SMP_CTRL_EE_RUN    16
`define SMP_CTRL_EE_DOUT   17
`define SMP_CTRL_EE_DOE    18
`define SMP_CTRL_RESET     32'h0000_0000

// Status register fields
`define SMP_ST_VALID       0
`define SMP_ST_EE_EN       1
`define SMP_ST_POWER_SAVING_STRAP     2
`define SMP_ST_PSTAT       3
`define SMP_ST_SMBUS       4
`define SMP_ST_DEBUG       5
`define SMP_ST_ADDR_LSB    8
`define SMP_ST_DSEL_LSB    16
`define SMP_ST_GPIO_LSB    24

// Link register fields
`define SMP_LK_REQ_LSB     0
`define SMP_LK_ON_LSB      4
`define SMP_LK_EE_DIN      8
`define SMP_LK_EE_CLK      9

// Timing
`define SMP_CLK_PERIOD_NS  5
`define SMP_EE_HALF_NS     1000
`define SMP_EE_HALF_CYC    (`SMP_EE_HALF_NS / `SMP_CLK_PERIOD_NS)
`define SMP_SETTLE_CYC     4

`endif

// File: rtl/smp_pkg.sv
// Types for the strap and miscellaneous pin control block.
// Assumes smp_cfg.svh holds all numeric constants.
`default_nettype none
package smp_pkg;

  // Strap levels caught once after reset
  typedef struct packed {
    logic eeprom_en;
    logic power_save;
    logic port_status_mode;
    logic smbus_mode;
    logic debug_mode;
  } smp_strap_s;

  // Pin input bundle, all from outside the clock domain
  typedef struct packed {
    logic       scan_test;
    logic [3:0] refclk_request_n;
    logic       debug_enable_strap;
    logic       mgmt_select_strap;
    logic       sideband_function_select;
    logic       power_saving_strap;
    logic [7:0] gpio;
    logic       eeprom_serial_data;
  } smp_pins_s;

  typedef enum logic [0:0] {SMP_SETTLE, SMP_RUN} smp_init_e;

endpackage : smp_pkg
`default_nettype wire

// File: rtl/smp_top.sv
// Strap latch, EEPROM pins, scan enable, GPIO and clock request pins.
// Assumes one 200 MHz clock, synchronous reset and an AHB-Lite master.
//
// Overview of operation
// - Device drives EEPROM serial clock output
// - EEPROM data pin is bidirectional
// - EEPROM data strap: low disables, high enables
// - Scan enable drives 0 unless test
// - GPIO direction set by output enable register
// - GPIO 7:5 give SMBus address bits 2:0
// - Debug mode: GPIO 4:0 select debug function
// - Power saving strap high enables power saving
// - Sideband select: low L1.1, high port status
// - Management strap: low I2C, high SMBus
// - Debug strap low enters debug mode
// - Clock request gates refclk; else status out
`include "smp_cfg.svh"
`default_nettype none
module smp_top
  import smp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Pins
  input  wire smp_pins_s   pins_in,
  output logic             eeprom_serial_clock,
  output logic             eeprom_serial_data_o,
  output logic             eeprom_serial_data_oe,
  output logic             scan_enable_o,
  output logic             scan_enable_oe,
  output logic      [7:0]  gpio_o,
  output logic      [7:0]  gpio_oe,
  output logic      [3:0]  refclk_request_n_o,
  output logic      [3:0]  refclk_request_n_oe,
  // Core side
  input  wire logic [3:0]  port_state_indicator,
  output smp_strap_s       strap_cfg,
  output logic             straps_valid,
  output logic             l1ss_enable,
  output logic      [2:0]  smbus_addr_lsb,
  output logic      [4:0]  debug_select,
  output logic      [3:0]  refclk_pll_on
);

  // --------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------
  localparam int PW = $bits(smp_pins_s);

  // Change accepted only when stages two and three agree
  function automatic logic [PW-1:0] smp_filter(
    input logic [PW-1:0] s2,
    input logic [PW-1:0] s3,
    input logic [PW-1:0] cur
  );
    logic [PW-1:0] same;
    same = ~(s2 ^ s3);
    return (same & s3) | (~same & cur);
  endfunction : smp_filter

  logic [PW-1:0] sync1_r;
  logic [PW-1:0] sync2_r;
  logic [PW-1:0] sync3_r;
  logic [PW-1:0] filt_r;
  smp_pins_s     pin_f;

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
      filt_r  <= '0;
    end else begin
      sync1_r <= pins_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      filt_r  <= smp_filter(sync2_r, sync3_r, filt_r);
    end
  end

  assign pin_f = smp_pins_s'(filt_r);

  // --------------------------------------------------------------
  // Strap capture
  // --------------------------------------------------------------
  // Wait for the synchroniser chain to fill before trusting straps
  smp_init_e  init_r;
  logic [2:0] settle_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      init_r   <= SMP_SETTLE;
      settle_r <= 3'h0;
    end else begin
      case (init_r)
        SMP_SETTLE: begin
          settle_r <= settle_r + 3'h1;
          if (settle_r == 3'(`SMP_SETTLE_CYC)) begin
            init_r <= SMP_RUN;
          end
        end
        SMP_RUN:    init_r <= SMP_RUN;
        default:    init_r <= SMP_SETTLE;
      endcase
    end
  end

  wire capture = (init_r == SMP_SETTLE) &&
                 (settle_r == 3'(`SMP_SETTLE_CYC));

  always_ff @(posedge clk) begin
    if (rst) begin
      strap_cfg      <= '0;
      straps_valid   <= 1'b0;
      l1ss_enable    <= 1'b0;
      smbus_addr_lsb <= 3'h0;
    end else if (capture) begin
      strap_cfg.eeprom_en        <= pin_f.eeprom_serial_data;
      strap_cfg.power_save       <= pin_f.power_saving_strap;
      strap_cfg.port_status_mode <= pin_f.sideband_function_select;
      l1ss_enable                <= ~pin_f.sideband_function_select;
      strap_cfg.smbus_mode       <= pin_f.mgmt_select_strap;
      strap_cfg.debug_mode       <= ~pin_f.debug_enable_strap;
      straps_valid               <= 1'b1;
      if (pin_f.mgmt_select_strap) begin
        smbus_addr_lsb <= pin_f.gpio[7:5];
      end
    end
  end

  // Selection follows GPIO 4:0 live while debug mode holds
  always_ff @(posedge clk) begin
    if (rst) begin
      debug_select <= 5'h00;
    end else if (strap_cfg.debug_mode) begin
      debug_select <= pin_f.gpio[4:0];
    end else begin
      debug_select <= 5'h00;
    end
  end

  // --------------------------------------------------------------
  // AHB-Lite slave
  // --------------------------------------------------------------
  logic [31:0]          ctrl_r;
  logic                 wr_pend_r;
  logic [`SMP_ADDR_W-1:0] wr_addr_r;
  logic                 ee_clk_r;

  wire take = hsel && htrans[1] && hready;

  function automatic logic [31:0] smp_read(
    input logic [`SMP_ADDR_W-1:0] a
  );
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      `SMP_ADDR_CTRL: v = ctrl_r;
      `SMP_ADDR_STATUS: begin
        v[`SMP_ST_VALID]   = straps_valid;
        v[`SMP_ST_EE_EN]   = strap_cfg.eeprom_en;
        v[`SMP_ST_POWER_SAVING_STRAP] = strap_cfg.power_save;
        v[`SMP_ST_PSTAT]   = strap_cfg.port_status_mode;
        v[`SMP_ST_SMBUS]   = strap_cfg.smbus_mode;
        v[`SMP_ST_DEBUG]   = strap_cfg.debug_mode;
        v[`SMP_ST_ADDR_LSB +: 3] = smbus_addr_lsb;
        v[`SMP_ST_DSEL_LSB +: 5] = debug_select;
        v[`SMP_ST_GPIO_LSB +: 8] = pin_f.gpio;
      end
      `SMP_ADDR_LINK: begin
        v[`SMP_LK_REQ_LSB +: 4] = ~pin_f.refclk_request_n;
        v[`SMP_LK_ON_LSB +: 4]  = refclk_pll_on;
        v[`SMP_LK_EE_DIN]       = pin_f.eeprom_serial_data;
        v[`SMP_LK_EE_CLK]       = ee_clk_r;
      end
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction : smp_read

  // Zero wait states: read data is fetched in the address phase
  always_ff @(posedge clk) begin
    if (rst) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_r <= take && hwrite;
      wr_addr_r <= haddr[`SMP_ADDR_W-1:0];
      if (take && !hwrite) begin
        hrdata <= smp_read(haddr[`SMP_ADDR_W-1:0]);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r <= `SMP_CTRL_RESET;
    end else if (wr_pend_r && wr_addr_r == `SMP_ADDR_CTRL) begin
      ctrl_r <= hwdata;
    end
  end

  // --------------------------------------------------------------
  // EEPROM pins
  // --------------------------------------------------------------
  localparam int EE_HALF = `SMP_EE_HALF_CYC;
  logic [7:0] ee_div_r;

  wire ee_run = ctrl_r[`SMP_CTRL_EE_RUN] && strap_cfg.eeprom_en;

  always_ff @(posedge clk) begin
    if (rst || !ee_run) begin
      ee_div_r <= 8'h00;
      ee_clk_r <= 1'b0;
    end else if (ee_div_r == 8'(EE_HALF - 1)) begin
      ee_div_r <= 8'h00;
      ee_clk_r <= ~ee_clk_r;
    end else begin
      ee_div_r <= ee_div_r + 8'h01;
    end
  end

  // Data pin never driven until the strap is captured
  always_ff @(posedge clk) begin
    if (rst) begin
      eeprom_serial_clock   <= 1'b0;
      eeprom_serial_data_o  <= 1'b0;
      eeprom_serial_data_oe <= 1'b0;
    end else begin
      eeprom_serial_clock   <= ee_clk_r;
      eeprom_serial_data_o  <= ctrl_r[`SMP_CTRL_EE_DOUT];
      eeprom_serial_data_oe <= ctrl_r[`SMP_CTRL_EE_DOE] &&
                               strap_cfg.eeprom_en;
    end
  end

  // --------------------------------------------------------------
  // Scan enable and GPIO
  // --------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      scan_enable_o  <= 1'b0;
      scan_enable_oe <= 1'b1;
    end else begin
      scan_enable_o  <= 1'b0;
      scan_enable_oe <= ~pin_f.scan_test;
    end
  end

  // Address straps on GPIO 7:5 are read before any output turns on
  always_ff @(posedge clk) begin
    if (rst) begin
      gpio_o  <= 8'h00;
      gpio_oe <= 8'h00;
    end else begin
      gpio_o  <= ctrl_r[`SMP_CTRL_OUT_LSB +: 8];
      gpio_oe <= straps_valid ? ctrl_r[`SMP_CTRL_OE_LSB +: 8]
                              : 8'h00;
    end
  end

  // --------------------------------------------------------------
  // Clock request and port status pins
  // --------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      refclk_request_n_o  <= 4'h0;
      refclk_request_n_oe <= 4'h0;
      refclk_pll_on       <= 4'hf;
    end else if (!straps_valid) begin
      refclk_request_n_o  <= 4'h0;
      refclk_request_n_oe <= 4'h0;
      refclk_pll_on       <= 4'hf;
    end else if (strap_cfg.port_status_mode) begin
      refclk_request_n_o  <= port_state_indicator;
      refclk_request_n_oe <= 4'hf;
      refclk_pll_on       <= 4'hf;
    end else begin
      refclk_request_n_o  <= 4'h0;
      refclk_request_n_oe <= 4'h0;
      refclk_pll_on       <= ~pin_f.refclk_request_n;
    end
  end

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_EE_CLK_HALF: assert property (
    $rose(ee_clk_r) && ee_run |=> (!$fell(ee_clk_r) || !$past(ee_run)) [*4])
    else $error("EEPROM clock half period too short");

  AST_EE_DOE_STRAP: assert property (
    !strap_cfg.eeprom_en |=> !eeprom_serial_data_oe)
    else $error("EEPROM data driven while EEPROM disabled");

  AST_STRAP_HOLD: assert property (
    straps_valid |=> $stable(strap_cfg) && straps_valid)
    else $error("Latched strap changed after capture");

  AST_STRAP_EE: assert property (
    capture |=> strap_cfg.eeprom_en == $past(pin_f.eeprom_serial_data))
    else $error("EEPROM strap captured wrongly");

  AST_SCAN_ZERO: assert property (
    !pin_f.scan_test |=> scan_enable_oe && !scan_enable_o)
    else $error("Scan enable not driven low");

  AST_GPIO_OE: assert property (
    $past(straps_valid) |->
      gpio_oe == $past(ctrl_r[`SMP_CTRL_OE_LSB +: 8]))
    else $error("GPIO direction does not follow register");

  AST_SMB_ADDR: assert property (
    capture && pin_f.mgmt_select_strap |=>
      smbus_addr_lsb == $past(pin_f.gpio[7:5]))
    else $error("SMBus address bits not taken from GPIO");

  AST_DEBUG_SEL: assert property (
    !strap_cfg.debug_mode |=> debug_select == 5'h00)
    else $error("Debug select outside debug mode");

  AST_MODES: assert property (
    capture |=> strap_cfg.power_save == $past(pin_f.power_saving_strap)
      && l1ss_enable == !strap_cfg.port_status_mode
      && strap_cfg.smbus_mode == $past(pin_f.mgmt_select_strap)
      && strap_cfg.debug_mode == !$past(pin_f.debug_enable_strap))
    else $error("Strap mode decoded wrongly");

  AST_PLL_GATE: assert property (
    straps_valid && l1ss_enable && pin_f.refclk_request_n[0] |=>
      !refclk_pll_on[0] && refclk_request_n_oe[0] == 1'b0)
    else $error("Reference clock not gated on released request");

  AST_VALID_TIME: assert property (
    $fell(rst) |-> ##[1:8] straps_valid)
    else $error("Straps not latched in time");

  COV_L1SS: cover property (l1ss_enable ##1 $changed(refclk_pll_on));
  COV_PSTAT: cover property (strap_cfg.port_status_mode &&
                             refclk_request_n_oe == 4'hf);
  COV_EE: cover property (ee_run ##1 $rose(eeprom_serial_clock));
  COV_DBG: cover property (strap_cfg.debug_mode && debug_select != 5'h00);

endmodule : smp_top
`default_nettype wire

// File: test/smp_board.sv
// Board model: strap levels, GPIO drivers and the EEPROM data line.
// Assumes the testbench sets strap levels before reset is released.
`default_nettype none
module smp_board
  import smp_pkg::*;
(
  input  wire logic       scan,
  input  wire logic [3:0] req_n,
  input  wire logic [3:0] straps,
  input  wire logic [7:0] gpio_drv,
  input  wire logic [7:0] gpio_o,
  input  wire logic [7:0] gpio_oe,
  input  wire logic       ee_drive,
  input  wire logic       ee_val,
  input  wire logic       ee_o,
  input  wire logic       ee_oe,
  output smp_pins_s       pins
);
  logic       ee_wire;
  logic [7:0] gpio_wire;
  // Released data line floats up through the pull-up
  assign ee_wire   = ee_oe ? ee_o : (ee_drive ? ee_val : 1'b1);
  assign gpio_wire = (gpio_oe & gpio_o) | (~gpio_oe & gpio_drv);
  assign pins      = {scan, req_n, straps, gpio_wire, ee_wire};
endmodule : smp_board
`default_nettype wire

// File: test/tb_strap_and_misc_pin_control.sv
// Self-checking bench for the strap and miscellaneous pin block.
// Assumes smp_top, the board model and a lone AHB-Lite master.
`include "smp_cfg.svh"
`default_nettype none
module tb_strap_and_misc_pin_control
  import smp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, hsel, hwrite, hready, ee_clk, ee_o, ee_oe, hresp;
  logic        scan, scan_o, scan_oe, ee_drive, ee_val, valid, l1ss;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [7:0]  gpio_drv, gpio_o, gpio_oe;
  logic [3:0]  straps, req_n, psi, rq_o, rq_oe, pll_on;
  logic [2:0]  smb;
  logic [4:0]  dsel;
  smp_strap_s  cfg;
  smp_pins_s   pins;
  int          failures, comparisons;

  smp_top uut (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .pins_in(pins),
    .eeprom_serial_clock(ee_clk), .eeprom_serial_data_o(ee_o),
    .eeprom_serial_data_oe(ee_oe), .scan_enable_o(scan_o),
    .scan_enable_oe(scan_oe), .gpio_o(gpio_o), .gpio_oe(gpio_oe),
    .refclk_request_n_o(rq_o), .refclk_request_n_oe(rq_oe),
    .port_state_indicator(psi), .strap_cfg(cfg), .straps_valid(valid),
    .l1ss_enable(l1ss), .smbus_addr_lsb(smb), .debug_select(dsel),
    .refclk_pll_on(pll_on));
  smp_board board (
    .scan(scan), .req_n(req_n), .straps(straps), .gpio_drv(gpio_drv),
    .gpio_o(gpio_o), .gpio_oe(gpio_oe), .ee_drive(ee_drive),
    .ee_val(ee_val), .ee_o(ee_o), .ee_oe(ee_oe), .pins(pins));

  always #2.5 clk = ~clk;
  // ------
  // Shared tasks
  // ------
  task automatic end_of_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [31:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Lands one edge's updates before anything is looked at
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    if (n >= 64) begin
      failures++;
      end_of_test();
    end
  endtask : wait_ready

  task automatic ahb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {20'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
    check("hresp", 0, hresp);
    #1;
  endtask : ahb

  task automatic do_reset(input logic [3:0] s, input logic [7:0] g,
                          input logic e);
    int n;
    @(posedge clk);
    rst      <= 1'b1;
    straps   <= s;
    gpio_drv <= g;
    ee_drive <= ~e;
    tick(15);
    check("scan oe in reset", 1, scan_oe);
    check("valid in reset", 0, valid);
    @(posedge clk);
    rst <= 1'b0;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (valid !== 1'b1 && n < 40);
    if (n >= 40) begin
      failures++;
      end_of_test();
    end
    check("capture edge", `SMP_SETTLE_CYC + 1, n);
    // Debug select follows the latched mode one edge later
    tick(1);
  endtask : do_reset
  // ------
  // Scenarios
  // ------
  task automatic scen_straps_on;
    do_reset(4'b0101, 8'hb6, 1'b1);
    check("straps", 5'b11011, cfg);
    check("l1ss", 1, l1ss);
    check("smb addr", 3'b101, smb);
    check("dbg sel", 5'h16, dsel);
    ahb(1'b0, `SMP_ADDR_STATUS, 0);
    check("status", 6'h37, rd[5:0]);
    @(posedge clk);
    straps   <= 4'b1010;
    gpio_drv <= 8'h0d;
    ee_drive <= 1'b1;
    tick(10);
    check("straps held", 5'b11011, cfg);
    check("smb held", 3'b101, smb);
    check("dbg live", 5'h0d, dsel);
    @(posedge clk);
    ee_drive <= 1'b0;
  endtask : scen_straps_on

  task automatic scen_scan;
    @(posedge clk);
    scan <= 1'b1;
    tick(8);
    check("scan oe test", 0, scan_oe);
    check("scan out", 0, scan_o);
    @(posedge clk);
    scan <= 1'b0;
    tick(8);
    check("scan oe run", 1, scan_oe);
  endtask : scen_scan

  task automatic scen_refclk;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      req_n <= k ? 4'b1010 : 4'b0101;
      tick(8);
      check("pll on", k ? 4'b0101 : 4'b1010, pll_on);
    end
    check("req oe", 0, rq_oe);
  endtask : scen_refclk

  task automatic scen_gpio;
    ahb(1'b1, `SMP_ADDR_CTRL, 32'h0000_050f);
    tick(2);
    check("gpio oe", 8'h0f, gpio_oe);
    check("gpio out", 8'h05, gpio_o);
    ahb(1'b0, `SMP_ADDR_CTRL, 0);
    check("ctrl read", 32'h050f, rd);
    tick(8);
    ahb(1'b0, `SMP_ADDR_STATUS, 0);
    check("gpio in", 8'h05, rd[31:24]);
    ahb(1'b0, 12'h010, 0);
    check("unmapped", 0, rd);
  endtask : scen_gpio

  task automatic scen_eeprom;
    logic c;
    int   n;
    ahb(1'b1, `SMP_ADDR_CTRL, 32'h0007_0000);
    tick(2);
    check("ee oe", 1, ee_oe);
    check("ee out", 1, ee_o);
    for (int k = 0; k < 2; k++) begin
      n = 0;
      c = ee_clk;
      while (ee_clk === c && n < 500) begin
        tick(1);
        n++;
      end
    end
    check("ee half period", `SMP_EE_HALF_CYC, n);
    ahb(1'b1, `SMP_ADDR_CTRL, 32'h0001_0000);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      ee_drive <= ~k[0];
      tick(8);
      ahb(1'b0, `SMP_ADDR_LINK, 0);
      check("ee data in", k[0], rd[8]);
    end
  endtask : scen_eeprom

  task automatic scen_straps_off;
    do_reset(4'b1010, 8'hea, 1'b0);
    check("straps b", 5'b00100, cfg);
    check("l1ss b", 0, l1ss);
    check("smb b", 0, smb);
    check("dbg b", 0, dsel);
    @(posedge clk);
    psi <= 4'b1001;
    tick(4);
    check("status out", 4'b1001, rq_o);
    check("status oe", 4'hf, rq_oe);
    ahb(1'b1, `SMP_ADDR_CTRL, 32'h0005_0000);
    tick(300);
    check("ee oe off", 0, ee_oe);
    check("ee clk off", 0, ee_clk);
  endtask : scen_straps_off

  initial begin
    clk         = 1'b0;
    rst         = 1'b1;
    hsel        = 1'b0;
    hwrite      = 1'b0;
    htrans      = 2'b00;
    haddr       = '0;
    hwdata      = '0;
    scan        = 1'b0;
    req_n       = 4'hf;
    straps      = 4'h0;
    gpio_drv    = 8'h00;
    ee_drive    = 1'b0;
    ee_val      = 1'b0;
    psi         = 4'h0;
    failures    = 0;
    comparisons = 0;
    scen_straps_on();
    scen_scan();
    scen_refclk();
    scen_gpio();
    scen_eeprom();
    scen_straps_off();
    end_of_test();
  end
endmodule : tb_strap_and_misc_pin_control
`default_nettype wire
